// File: logic/css_regs.svh
// register offsets, field positions, reset values and timing counts of the scan controller
// assumes a 12-bit apb byte address and field timing taken from the sandcastle pulse
`ifndef CSS_REGS_SVH
`define CSS_REGS_SVH

// ==========================================================
// register offsets
`define CSS_CTRL_OFS 12'h000
`define CSS_STATUS_OFS 12'h004
`define CSS_IRQ_STAT_OFS 12'h008
`define CSS_IRQ_CLR_OFS 12'h00C
`define CSS_IRQ_EN_OFS 12'h010

// ==========================================================
// field positions
`define CSS_CTRL_AUTO_BIT 0
`define CSS_CTRL_RESTART_BIT 1
`define CSS_ST_SEL_LSB 0
`define CSS_ST_STATE_LSB 4
`define CSS_ST_COLOUR_BIT 6
`define CSS_ST_FORCED_BIT 7
`define CSS_ST_SECAM_BIT 8
`define CSS_IRQ_RECOG_BIT 0
`define CSS_IRQ_COLOUR_BIT 1
`define CSS_IRQ_LOSS_BIT 2
`define CSS_IRQ_STEP_BIT 3
`define CSS_IRQ_W 4

// ==========================================================
// reset values
`define CSS_AUTO_RST 1'h1
`define CSS_IRQ_EN_RST 4'h0
`define CSS_SEL_OE_RST 4'hF

// ==========================================================
// timing, in milliseconds and in field periods
`define CSS_FIELD_MS 20
`define CSS_DWELL_MS 80
`define CSS_CWAIT_MS 40
`define CSS_LOSS_MS 40
`define CSS_DWELL_FIELDS (`CSS_DWELL_MS / `CSS_FIELD_MS)
`define CSS_CWAIT_FIELDS (`CSS_CWAIT_MS / `CSS_FIELD_MS)
`define CSS_LOSS_FIELDS (`CSS_LOSS_MS / `CSS_FIELD_MS)

// ==========================================================
// sandcastle level thresholds, 8-bit sample codes
`define CSS_SC_VBL_TH 8'h30
`define CSS_SC_HBL_TH 8'h5A
`define CSS_SC_BURST_TH 8'hB3

`endif

// File: logic/css_pkg.sv
// types and helper functions of the colour standard scan controller
// does not use css_regs.svh; its numeric constants are written out here
package css_pkg;

   // ==========================================================
   // enumerations
   typedef enum logic [1:0] {
      CSS_SCAN = 2'h0,
      CSS_CWAIT = 2'h1,
      CSS_LOCK = 2'h3,
      CSS_LWAIT = 2'h2
   } css_state_e;

   typedef enum logic [1:0] {
      CSS_PAL = 2'h0,
      CSS_SECAM = 2'h1,
      CSS_N35 = 2'h2,
      CSS_N44 = 2'h3
   } css_std_e;

   // ==========================================================
   // decoded sandcastle pulses
   typedef struct packed {
      logic burst_key;
      logic hblank;
      logic vblank;
      logic field_tick;
   } css_sc_s;

   // ==========================================================
   // standard helpers
   function automatic css_std_e css_next_std(input css_std_e s);
      css_next_std = css_std_e'(s + 2'h1);
   endfunction : css_next_std

   function automatic logic [3:0] css_onehot(input css_std_e s);
      css_onehot = 4'h1 << s;
   endfunction : css_onehot

   // lowest forced line wins if several are forced
   function automatic css_std_e css_first_std(input logic [3:0] f);
      css_first_std = CSS_PAL;
      if (f[0]) css_first_std = CSS_PAL;
      else if (f[1]) css_first_std = CSS_SECAM;
      else if (f[2]) css_first_std = CSS_N35;
      else if (f[3]) css_first_std = CSS_N44;
   endfunction : css_first_std

endpackage : css_pkg

// File: logic/css_sandcastle.sv
// sandcastle level detector: burst key, line and field blanking, field tick
// assumes a digitised sandcastle sample synchronous to clock_i
`include "css_regs.svh"

module css_sandcastle #(
   parameter int LVL_W = 8
) (
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // sampled pulse level
   input wire logic [LVL_W-1:0] level_i,
   // decoded pulses
   output css_pkg::css_sc_s sc_o
);

   typedef struct packed {
      css_pkg::css_sc_s sc;
   } css_scd_s;

   css_scd_s st_r;
   css_scd_s st_nxt;

   // ==========================================================
   // level slicing
   always_comb begin
      st_nxt = st_r;
      st_nxt.sc.burst_key = level_i >= LVL_W'(`CSS_SC_BURST_TH);
      st_nxt.sc.hblank = level_i >= LVL_W'(`CSS_SC_HBL_TH);
      st_nxt.sc.vblank = level_i >= LVL_W'(`CSS_SC_VBL_TH);
      st_nxt.sc.field_tick = st_nxt.sc.vblank && !st_r.sc.vblank;
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign sc_o = st_r.sc;

   // ==========================================================
   // checks
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);

   burst_slice_a: assert property (sc_o.burst_key == ($past(level_i) >= LVL_W'(`CSS_SC_BURST_TH)))
      else $error("burst key does not follow top level");
   tick_edge_a: assert property (sc_o.field_tick |-> sc_o.vblank && !$past(sc_o.vblank))
      else $error("field tick without vblank rise");

endmodule : css_sandcastle

// File: logic/css_top.sv
// colour standard scan controller with apb register slave and interrupt
// assumes synchronous inputs, a digitised sandcastle and a level match indication
//
// Behaviour
// - with nothing recognised the standard steps PAL, SECAM, NTSC-3.5, NTSC-4.4 and wraps.
// - each standard dwells four field periods (80 ms) and then the next one is tried.
// - colour is switched on two field periods after recognition (360 ms worst case).
// - the PAL check after SECAM may add one more dwell (440 ms worst case).
// - a first SECAM match is remembered and the decoder is switched to PAL instead.
// - SECAM is accepted on the second detection only when the PAL trial did not match.
// - scanning runs while there is no match and stops on the matching standard.
// - scanning restarts when the input standard changes or the signal fades away.
// - loss of recognition waits two field periods (40 ms) before scanning restarts.
// - monochrome input gives no match, so scanning goes on and colour stays off.
// - the select outputs are one-hot, only the active standard is high.
// - each select line is both a forcing input and a standard indicator output.
// - colour switch-off on a missing match works in automatic and forced operation.
// - burst key, line and field blanking are sliced from one three-level pulse.
// - a match input says whether the active standard fits the incoming signal.
//
// Local design decisions: the register addresses and register access over APB.
`include "css_regs.svh"

module css_top #(
   parameter int LVL_W = 8,
   parameter int AW = 12
) (
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [AW-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // sandcastle and recognition
   input wire logic [LVL_W-1:0] sc_level_i,
   input wire logic match_i,
   output logic burst_key_o,
   output logic hblank_o,
   output logic vblank_o,
   // standard select lines
   input wire logic [3:0] std_sel_i,
   output logic [3:0] std_sel_o,
   output logic [3:0] std_sel_oe_o,
   // colour and interrupt
   output logic colour_on_o,
   output logic irq_o
);

   typedef struct packed {
      css_pkg::css_state_e state;
      css_pkg::css_std_e std;
      logic [2:0] dwell;
      logic [1:0] fcnt;
      logic secam_seen;
      logic colour_on;
      logic auto_en;
      logic [`CSS_IRQ_W-1:0] irq_stat;
      logic [`CSS_IRQ_W-1:0] irq_en;
      logic irq;
      logic [3:0] sel;
      logic [3:0] sel_oe;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } css_top_s;

   localparam css_top_s RST_VAL = '{
      state: css_pkg::CSS_SCAN,
      std: css_pkg::CSS_PAL,
      dwell: 3'h0,
      fcnt: 2'h0,
      secam_seen: 1'h0,
      colour_on: 1'h0,
      auto_en: `CSS_AUTO_RST,
      irq_stat: 4'h0,
      irq_en: `CSS_IRQ_EN_RST,
      irq: 1'h0,
      sel: 4'h1,
      sel_oe: `CSS_SEL_OE_RST,
      pready: 1'h0,
      pslverr: 1'h0,
      prdata: 32'h0
   };

   css_top_s st_r;
   css_top_s st_nxt;
   css_pkg::css_sc_s sc;

   // ==========================================================
   // sandcastle slicing
   css_sandcastle #(
      .LVL_W(LVL_W)
   ) u_sc (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .level_i(sc_level_i),
      .sc_o(sc)
   );

   // ==========================================================
   // next state
   always_comb begin
      logic forced;
      logic hold;
      logic tick;
      logic acc_wr;
      logic restart;
      css_pkg::css_std_e fstd;
      logic [`CSS_IRQ_W-1:0] ev;
      logic [`CSS_IRQ_W-1:0] clr;
      logic [31:0] rd;
      forced = |std_sel_i;
      fstd = css_pkg::css_first_std(std_sel_i);
      tick = sc.field_tick;
      ev = '0;
      clr = '0;
      rd = '0;
      restart = 1'b0;
      acc_wr = psel_i && penable_i && st_r.pready && pwrite_i && !st_r.pslverr;
      st_nxt = st_r;
      hold = forced || !st_r.auto_en;

      // apb: answer registered in setup, zero wait states
      st_nxt.pready = psel_i && !penable_i;
      st_nxt.pslverr = 1'b0;
      st_nxt.prdata = '0;
      if (psel_i && !penable_i) begin
         unique case (paddr_i)
            `CSS_CTRL_OFS: begin
               rd[`CSS_CTRL_AUTO_BIT] = st_r.auto_en;
            end
            `CSS_STATUS_OFS: begin
               rd[`CSS_ST_SEL_LSB +: 4] = st_r.sel;
               rd[`CSS_ST_STATE_LSB +: 2] = st_r.state;
               rd[`CSS_ST_COLOUR_BIT] = st_r.colour_on;
               rd[`CSS_ST_FORCED_BIT] = forced;
               rd[`CSS_ST_SECAM_BIT] = st_r.secam_seen;
            end
            `CSS_IRQ_STAT_OFS: begin
               rd[`CSS_IRQ_W-1:0] = st_r.irq_stat;
            end
            `CSS_IRQ_CLR_OFS: begin
               rd = '0;
            end
            `CSS_IRQ_EN_OFS: begin
               rd[`CSS_IRQ_W-1:0] = st_r.irq_en;
            end
            default: begin
               st_nxt.pslverr = 1'b1;
            end
         endcase
         st_nxt.prdata = rd;
      end
      if (acc_wr) begin
         if (paddr_i == `CSS_CTRL_OFS) begin
            st_nxt.auto_en = pwdata_i[`CSS_CTRL_AUTO_BIT];
            restart = pwdata_i[`CSS_CTRL_RESTART_BIT];
         end
         if (paddr_i == `CSS_IRQ_CLR_OFS) begin
            clr = pwdata_i[`CSS_IRQ_W-1:0];
         end
         if (paddr_i == `CSS_IRQ_EN_OFS) begin
            st_nxt.irq_en = pwdata_i[`CSS_IRQ_W-1:0];
         end
      end

      // scan sequencer
      unique case (st_r.state)
         css_pkg::CSS_SCAN: begin
            if (forced) begin
               st_nxt.std = fstd;
            end
            if (match_i) begin
               if (!forced && st_r.std == css_pkg::CSS_SECAM && !st_r.secam_seen) begin
                  st_nxt.secam_seen = 1'b1;
                  st_nxt.std = css_pkg::CSS_PAL;
                  st_nxt.dwell = 3'h0;
               end else begin
                  st_nxt.state = css_pkg::CSS_CWAIT;
                  st_nxt.secam_seen = 1'b0;
                  st_nxt.fcnt = 2'h0;
                  ev[`CSS_IRQ_RECOG_BIT] = 1'b1;
               end
            end else if (tick && !hold) begin
               if (st_r.dwell == 3'(`CSS_DWELL_FIELDS - 1)) begin
                  st_nxt.dwell = 3'h0;
                  st_nxt.std = css_pkg::css_next_std(st_r.std);
                  ev[`CSS_IRQ_STEP_BIT] = 1'b1;
                  if (st_r.std == css_pkg::CSS_SECAM) begin
                     st_nxt.secam_seen = 1'b0;
                  end
               end else begin
                  st_nxt.dwell = st_r.dwell + 3'h1;
               end
            end
         end
         css_pkg::CSS_CWAIT: begin
            if (!match_i) begin
               st_nxt.state = css_pkg::CSS_LWAIT;
               st_nxt.fcnt = 2'h0;
               ev[`CSS_IRQ_LOSS_BIT] = 1'b1;
            end else if (tick) begin
               if (st_r.fcnt == 2'(`CSS_CWAIT_FIELDS - 1)) begin
                  st_nxt.state = css_pkg::CSS_LOCK;
                  ev[`CSS_IRQ_COLOUR_BIT] = 1'b1;
               end else begin
                  st_nxt.fcnt = st_r.fcnt + 2'h1;
               end
            end
         end
         css_pkg::CSS_LOCK: begin
            if (!match_i) begin
               st_nxt.state = css_pkg::CSS_LWAIT;
               st_nxt.fcnt = 2'h0;
               ev[`CSS_IRQ_LOSS_BIT] = 1'b1;
            end
         end
         css_pkg::CSS_LWAIT: begin
            if (match_i) begin
               st_nxt.state = css_pkg::CSS_LOCK;
            end else if (tick) begin
               if (st_r.fcnt == 2'(`CSS_LOSS_FIELDS - 1)) begin
                  st_nxt.state = css_pkg::CSS_SCAN;
                  st_nxt.dwell = 3'h0;
               end else begin
                  st_nxt.fcnt = st_r.fcnt + 2'h1;
               end
            end
         end
      endcase

      // forced change or software restart drops back to scanning
      if ((forced && st_r.state != css_pkg::CSS_SCAN && fstd != st_r.std) || restart) begin
         st_nxt.state = css_pkg::CSS_SCAN;
         st_nxt.dwell = 3'h0;
         st_nxt.secam_seen = 1'b0;
         if (forced) begin
            st_nxt.std = fstd;
         end
      end

      st_nxt.colour_on = st_nxt.state == css_pkg::CSS_LOCK;
      st_nxt.sel = css_pkg::css_onehot(st_nxt.std);
      st_nxt.sel_oe = ~std_sel_i;
      // set wins over clear
      st_nxt.irq_stat = (st_r.irq_stat & ~clr) | ev;
      st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_en);
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         st_r <= RST_VAL;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ==========================================================
   // outputs
   assign prdata_o = st_r.prdata;
   assign pready_o = st_r.pready;
   assign pslverr_o = st_r.pslverr;
   assign burst_key_o = sc.burst_key;
   assign hblank_o = sc.hblank;
   assign vblank_o = sc.vblank;
   assign std_sel_o = st_r.sel;
   assign std_sel_oe_o = st_r.sel_oe;
   assign colour_on_o = st_r.colour_on;
   assign irq_o = st_r.irq;

   // ==========================================================
   // checks
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);

   sequence s_scan_free;
      st_r.state == css_pkg::CSS_SCAN && !(|std_sel_i) && !match_i;
   endsequence

   sequence s_secam_first;
      st_r.state == css_pkg::CSS_SCAN && !(|std_sel_i) && match_i
         && st_r.std == css_pkg::CSS_SECAM && !st_r.secam_seen;
   endsequence

   sequence s_secam_second;
      st_r.state == css_pkg::CSS_SCAN && match_i && st_r.std == css_pkg::CSS_SECAM
         && st_r.secam_seen;
   endsequence

   one_hot_sel_a: assert property ($onehot(std_sel_o))
      else $error("select outputs not one-hot");
   dwell_step_a: assert property (s_scan_free ##0 (sc.field_tick && st_r.auto_en
         && st_r.dwell == 3'(`CSS_DWELL_FIELDS - 1)) |=> std_sel_o
         == css_pkg::css_onehot(css_pkg::css_next_std($past(st_r.std))))
      else $error("standard did not step after dwell");
   dwell_hold_a: assert property (s_scan_free ##0 (st_r.dwell != 3'(`CSS_DWELL_FIELDS - 1))
         |=> st_r.std == $past(st_r.std))
      else $error("standard left before dwell ended");
   secam_to_pal_a: assert property (s_secam_first |=> st_r.std == css_pkg::CSS_PAL
         && st_r.secam_seen && st_r.state == css_pkg::CSS_SCAN)
      else $error("first secam match not turned to pal");
   secam_accept_a: assert property (s_secam_second |=> st_r.state == css_pkg::CSS_CWAIT
         && !st_r.secam_seen)
      else $error("second secam match not accepted");
   colour_delay_a: assert property ($rose(colour_on_o) |-> $past(st_r.state)
         inside {css_pkg::CSS_CWAIT, css_pkg::CSS_LWAIT})
      else $error("colour switched on without recognition wait");
   colour_off_a: assert property (colour_on_o && !match_i && !$past(rst_i)
         |=> !colour_on_o ##1 (!colour_on_o || $past(match_i)))
      else $error("colour stayed on without match");
   loss_wait_a: assert property ($rose(st_r.state == css_pkg::CSS_LWAIT) ##1
         (!sc.field_tick && !match_i) |=> st_r.state == css_pkg::CSS_LWAIT)
      else $error("scan restarted before loss delay");
   loss_first_a: assert property (st_r.state == css_pkg::CSS_LWAIT
         && st_r.fcnt == 2'h0 && sc.field_tick && !match_i && !(|std_sel_i)
         |=> st_r.state == css_pkg::CSS_LWAIT)
      else $error("scan restarted on first loss field");
   force_hold_a: assert property (std_sel_i == 4'h4 ##1 std_sel_i == 4'h4
         |-> std_sel_o == 4'h4 && std_sel_oe_o == 4'hB)
      else $error("forced standard not held");
   reset_pal_a: assert property ($fell(rst_i) |-> std_sel_o == 4'h1 && !colour_on_o)
      else $error("reset did not start on pal");

endmodule : css_top

// File: testbench/css_far_side.sv
// far side of the scan controller: sandcastle source, match detector, forcing switches
// assumes the bench sets the accepted standards and the forced lines directly
module css_far_side (
   // clock
   input wire logic clock_i,
   // bench controls
   input wire logic fields_on_i,
   input wire logic [7:0] man_level_i,
   input wire logic [3:0] accept_i,
   input wire logic [3:0] force_sel_i,
   // decoder side
   input wire logic [3:0] std_sel_i,
   input wire logic [3:0] std_sel_oe_i,
   output logic [7:0] sc_level_o,
   output logic match_o,
   output logic [3:0] forced_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================================
   // field generator, 32 cycles a field
   logic [4:0] pos_r;

   always_ff @(posedge clock_i) begin
      if (!fields_on_i) begin
         pos_r <= 5'h00;
      end else begin
         pos_r <= pos_r + 5'h01;
      end
   end

   // pulse parked at the manual level outside field mode
   assign sc_level_o = !fields_on_i ? man_level_i : (pos_r < 5'h04 ? 8'h40 : 8'h00);

   // ==========================================================
   // match detector and forcing switches
   assign match_o = |(std_sel_i & accept_i);
   // a forced line wins over the decoder's own drive
   assign forced_o = force_sel_i & (std_sel_oe_i | force_sel_i);
endmodule : css_far_side

// File: testbench/css_top_bench.sv
// self-checking bench of the colour standard scan controller
// assumes css_top, css_far_side and css_regs.svh on the compile path
`include "css_regs.svh"

module css_top_bench;
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================================
   // signals
   logic clock_i = 1'b0;
   logic rst_i = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [7:0] sc_level;
   logic match;
   logic burst;
   logic hbl;
   logic vbl;
   logic [3:0] sel_in;
   logic [3:0] sel_o;
   logic [3:0] sel_oe;
   logic colour_on;
   logic irq;
   logic fields_on = 1'b0;
   logic [7:0] man_level = 8'h00;
   logic [3:0] accept = 4'h0;
   logic [3:0] force_sel = 4'h0;
   logic [31:0] rd;
   logic err;
   int mismatches = 0;
   int tests_run = 0;
   int cyc = 0;
   localparam int LIMIT = 20000;
   logic [7:0] lv [8] = '{8'h00, 8'h2F, 8'h30, 8'h59, 8'h5A, 8'hB2, 8'hB3, 8'hFF};
   logic [2:0] ex [8] = '{3'h0, 3'h0, 3'h1, 3'h1, 3'h3, 3'h3, 3'h7, 3'h7};

   css_top DUT (
      .clock_i(clock_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .sc_level_i(sc_level), .match_i(match),
      .burst_key_o(burst), .hblank_o(hbl), .vblank_o(vbl), .std_sel_i(sel_in),
      .std_sel_o(sel_o), .std_sel_oe_o(sel_oe), .colour_on_o(colour_on), .irq_o(irq)
   );

   css_far_side far (
      .clock_i(clock_i), .fields_on_i(fields_on), .man_level_i(man_level),
      .accept_i(accept), .force_sel_i(force_sel), .std_sel_i(sel_o),
      .std_sel_oe_i(sel_oe), .sc_level_o(sc_level), .match_o(match), .forced_o(sel_in)
   );

   always #2.5 clock_i = ~clock_i;

   always @(posedge clock_i) begin
      cyc++;
      if (cyc >= LIMIT) begin
         mismatches++;
         close_out();
      end
   end

   // ==========================================================
   // tasks
   task close_out();
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : close_out

   task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   // one apb transfer, waits for pready, then one idle cycle
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock_i);
      penable <= 1'b1;
      do begin
         @(posedge clock_i);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock_i);
   endtask : apb

   task fields(input int n);
      repeat (n) @(posedge vbl);
      repeat (3) @(posedge clock_i);
   endtask : fields

   task do_reset();
      rst_i <= 1'b1;
      fields_on <= 1'b0;
      man_level <= 8'h00;
      accept <= 4'h0;
      force_sel <= 4'h0;
      repeat (16) @(posedge clock_i);
      rst_i <= 1'b0;
      @(posedge clock_i);
   endtask : do_reset

   // ==========================================================
   // main sequence
   initial begin
      do_reset();
      for (int i = 0; i < 8; i++) begin
         man_level <= lv[i];
         repeat (2) @(posedge clock_i);
         chk("slicer", 32'({burst, hbl, vbl}), 32'(ex[i]));
      end
      // the slicer rows raised vblank once: start the field count afresh
      do_reset();
      chk("sel", 32'(sel_o), 32'h1);
      chk("oe", 32'(sel_oe), 32'hF);
      chk("irq", 32'(irq), 32'h0);
      apb(1'b0, `CSS_CTRL_OFS, 32'h0);
      chk("ctrl", rd, 32'h1);
      apb(1'b1, `CSS_STATUS_OFS, 32'hFFFF);
      apb(1'b0, `CSS_STATUS_OFS, 32'h0);
      chk("status", rd, 32'h1);
      apb(1'b0, `CSS_IRQ_EN_OFS, 32'h0);
      chk("irq_en", rd, 32'h0);
      apb(1'b0, 12'h020, 32'h0);
      chk("slverr", 32'(err), 32'h1);
      // monochrome scan round
      fields_on <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         fields(3);
         chk("dwell", 32'(sel_o), 32'(4'h1 << i));
         fields(1);
         chk("step", 32'(sel_o), 32'(4'h1 << ((i + 1) % 4)));
         chk("mono colour", 32'(colour_on), 32'h0);
      end
      chk("irq masked", 32'(irq), 32'h0);
      apb(1'b0, `CSS_IRQ_STAT_OFS, 32'h0);
      chk("step stat", rd & 32'h8, 32'h8);
      apb(1'b1, `CSS_IRQ_EN_OFS, 32'h8);
      repeat (2) @(posedge clock_i);
      chk("irq on", 32'(irq), 32'h1);
      apb(1'b1, `CSS_CTRL_OFS, 32'h0);
      fields(5);
      chk("auto off", 32'(sel_o), 32'h1);
      fields_on <= 1'b0;
      apb(1'b1, `CSS_IRQ_CLR_OFS, 32'h8);
      repeat (2) @(posedge clock_i);
      chk("irq clr", 32'(irq), 32'h0);
      // secam remembered, pal tried first
      do_reset();
      accept <= 4'h2;
      fields_on <= 1'b1;
      fields(4);
      chk("secam to pal", 32'(sel_o), 32'h1);
      apb(1'b0, `CSS_STATUS_OFS, 32'h0);
      chk("secam seen", 32'(rd[8]), 32'h1);
      fields(3);
      chk("pal trial", 32'(sel_o), 32'h1);
      fields(1);
      chk("secam accept", 32'(sel_o), 32'h2);
      apb(1'b0, `CSS_STATUS_OFS, 32'h0);
      chk("cwait", 32'(rd[5:4]), 32'h1);
      fields(1);
      chk("colour early", 32'(colour_on), 32'h0);
      fields(1);
      chk("colour", 32'(colour_on), 32'h1);
      apb(1'b0, `CSS_IRQ_STAT_OFS, 32'h0);
      chk("recog stat", rd, 32'hB);
      // pal match beats secam
      do_reset();
      fields_on <= 1'b1;
      fields(4);
      accept <= 4'h3;
      repeat (3) @(posedge clock_i);
      chk("pal wins", 32'(sel_o), 32'h1);
      fields(2);
      chk("pal colour", 32'(colour_on), 32'h1);
      // loss, short dropout, restart
      accept <= 4'h0;
      repeat (3) @(posedge clock_i);
      chk("colour off", 32'(colour_on), 32'h0);
      fields(1);
      accept <= 4'h1;
      repeat (3) @(posedge clock_i);
      chk("colour back", 32'(colour_on), 32'h1);
      accept <= 4'h0;
      fields(1);
      apb(1'b0, `CSS_STATUS_OFS, 32'h0);
      chk("lwait", 32'(rd[5:4]), 32'h2);
      apb(1'b0, `CSS_IRQ_STAT_OFS, 32'h0);
      chk("loss stat", rd & 32'h4, 32'h4);
      fields(1);
      apb(1'b0, `CSS_STATUS_OFS, 32'h0);
      chk("rescan", 32'(rd[5:4]), 32'h0);
      fields(3);
      chk("rescan dwell", 32'(sel_o), 32'h1);
      fields(1);
      chk("rescan step", 32'(sel_o), 32'h2);
      // forced standard
      do_reset();
      force_sel <= 4'h4;
      fields_on <= 1'b1;
      fields(1);
      chk("forced sel", 32'(sel_o), 32'h4);
      chk("forced oe", 32'(sel_oe), 32'hB);
      apb(1'b0, `CSS_STATUS_OFS, 32'h0);
      chk("forced status", rd, 32'h84);
      fields(6);
      chk("forced hold", 32'(sel_o), 32'h4);
      chk("forced off", 32'(colour_on), 32'h0);
      accept <= 4'h4;
      fields(2);
      chk("forced on", 32'(colour_on), 32'h1);
      // software restart drops colour and runs recognition again
      apb(1'b1, `CSS_CTRL_OFS, 32'h3);
      chk("restart off", 32'(colour_on), 32'h0);
      fields(2);
      chk("restart on", 32'(colour_on), 32'h1);
      close_out();
   end
endmodule : css_top_bench
